// *** design/acsrs_pkg.sv ***
/*
 * package for the channel sequencer and range select block: channel count,
 * range code values, mode enumeration and the grouped sample descriptor.
 * assumes nothing of its surroundings beyond a sv-2012 compiler.
 */
package acsrs_pkg;
  localparam int NUM_CH = 8;
  localparam int CH_W = 3;
  localparam int RANGE_W = 4;
  // range codes
  localparam logic [RANGE_W-1:0] RANGE_BIP_2P5 = 4'h0;
  localparam logic [RANGE_W-1:0] RANGE_BIP_1P25 = 4'h1;
  localparam logic [RANGE_W-1:0] RANGE_BIP_0P625 = 4'h2;
  localparam logic [RANGE_W-1:0] RANGE_UNI_2P5 = 4'h5;
  localparam logic [RANGE_W-1:0] RANGE_UNI_1P25 = 4'h6;
  localparam logic [RANGE_W-1:0] RANGE_RESET = RANGE_BIP_2P5;
  localparam logic [NUM_CH-1:0] SCAN_EN_RESET = 8'hff;
  localparam logic [CH_W-1:0] CH_RESET = 3'h0;
  // aggregate rate ceiling the host must respect, in samples per second
  localparam int MAX_AGG_SPS = 500000;
  localparam int CLK_HZ = 125000000;
  localparam int MIN_SAMPLE_CYC = (CLK_HZ + MAX_AGG_SPS - 1) / MAX_AGG_SPS;

  typedef enum logic {
    ACSRS_MODE_MANUAL,
    ACSRS_MODE_AUTO
  } acsrs_mode_t;

  // what the converter core needs for the sample now being taken
  typedef struct packed {
    logic [CH_W-1:0] channel;
    logic [RANGE_W-1:0] range_code;
    logic bipolar;
  } acsrs_sample_t;
endpackage : acsrs_pkg

// *** design/acsrs_next_ch.sv ***
/*
 * combinational picker of the next enabled channel above the current one,
 * wrapping to the lowest enabled channel. assumes same-clock inputs.
 */
module acsrs_next_ch (
  input wire logic [acsrs_pkg::CH_W-1:0] i_cur,
  input wire logic [acsrs_pkg::NUM_CH-1:0] i_en,
  output logic [acsrs_pkg::CH_W-1:0] o_next,
  output logic o_any
);
  import acsrs_pkg::*;

  logic [NUM_CH-1:0] above;
  logic [CH_W-1:0] first_above;
  logic [CH_W-1:0] first_any;
  logic found_above;

  // mask of enabled channels strictly above the current one
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_above
      assign above[g] = i_en[g] && (g > int'(i_cur));
    end
  endgenerate

  // priority search from the top down so the lowest index wins
  always_comb begin
    first_above = CH_RESET;
    first_any = CH_RESET;
    found_above = 1'b0;
    for (int k = NUM_CH - 1; k >= 0; k--) begin
      if (above[k]) begin
        first_above = CH_W'(k);
        found_above = 1'b1;
      end
      if (i_en[k]) begin
        first_any = CH_W'(k);
      end
    end
  end

  assign o_any = |i_en;
  assign o_next = found_above ? first_above : first_any;
endmodule : acsrs_next_ch

// *** design/acsrs_top.sv ***
/*
 * channel sequencer and input range select of a multichannel sar front end.
 * holds a range code per channel, sets the mux by manual command or steps it in auto-scan mode
 * on chip-select falling edges and steers the reference pin from a strap.
 * assumes the serial decoder runs on i_clk_sys and hands over one-cycle
 * write strobes; chip select and the strap pin are asynchronous pins.
 */
// Operation
// - each channel owns a four-bit range code
// - range codes reset to bipolar 2.5 x vref
// - manual mode converts most recently written channel
// - auto-scan advances channel on chip-select fall
// - scan only enabled channels, ascending order
// - strap low: internal reference, pin drives out
// - strap high: external reference, pin is input
module acsrs_top (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_cs_n,
  input wire logic i_range_wr,
  input wire logic [acsrs_pkg::CH_W-1:0] i_range_ch,
  input wire logic [acsrs_pkg::RANGE_W-1:0] i_range_code,
  input wire logic i_manual_channel_select_command,
  input wire logic [acsrs_pkg::CH_W-1:0] i_manual_ch,
  input wire logic i_auto_start,
  input wire logic i_scan_en_wr,
  input wire logic [acsrs_pkg::NUM_CH-1:0] i_scan_en,
  input wire logic i_reference_source_pin,
  input wire logic i_reference_inout_pin,
  output acsrs_pkg::acsrs_sample_t o_sample,
  output logic o_sample_strobe,
  output acsrs_pkg::acsrs_mode_t o_mode,
  output logic [acsrs_pkg::NUM_CH-1:0] o_scan_en,
  output logic [acsrs_pkg::NUM_CH*acsrs_pkg::RANGE_W-1:0] o_channel_input_range_code,
  output logic o_ref_internal,
  output logic o_reference_inout_pin,
  output logic o_reference_inout_pin_oe,
  output logic o_ref_sense
);
  import acsrs_pkg::*;

  logic [RANGE_W-1:0] channel_input_range_code [NUM_CH];
  logic [NUM_CH-1:0] scan_en;
  acsrs_mode_t mode;
  logic [CH_W-1:0] cur_ch;
  logic [CH_W-1:0] next_ch;
  logic any_en;
  logic cs_meta, cs_sync, cs_prev;
  logic refsrc_meta, refsrc_sync;
  logic refpin_meta, refpin_sync;
  logic cs_fall;

  // two-flop synchronisers for the pins; the first stage feeds only the second
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      cs_prev <= 1'b1;
      refsrc_meta <= 1'b0;
      refsrc_sync <= 1'b0;
      refpin_meta <= 1'b0;
      refpin_sync <= 1'b0;
    end else if (i_ce) begin
      cs_meta <= i_cs_n;
      cs_sync <= cs_meta;
      cs_prev <= cs_sync;
      refsrc_meta <= i_reference_source_pin;
      refsrc_sync <= refsrc_meta;
      refpin_meta <= i_reference_inout_pin;
      refpin_sync <= refpin_meta;
    end
  end

  assign cs_fall = cs_prev && !cs_sync;

  // range code bank, one entry per channel, written by index
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      for (int k = 0; k < NUM_CH; k++) begin
        channel_input_range_code[k] <= RANGE_RESET;
      end
    end else if (i_ce && i_range_wr) begin
      channel_input_range_code[i_range_ch] <= i_range_code;
    end
  end

  // scan selection; all channels enabled out of reset
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      scan_en <= SCAN_EN_RESET;
    end else if (i_ce && i_scan_en_wr) begin
      scan_en <= i_scan_en;
    end
  end

  acsrs_next_ch u_next (
    .i_cur(cur_ch),
    .i_en(scan_en),
    .o_next(next_ch),
    .o_any(any_en)
  );

  // mode and channel pointer; a manual write wins over an auto start
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      mode <= ACSRS_MODE_MANUAL;
      cur_ch <= CH_RESET;
    end else if (i_ce) begin
      if (i_manual_channel_select_command) begin
        mode <= ACSRS_MODE_MANUAL;
        cur_ch <= i_manual_ch;
      end else if (i_auto_start) begin
        mode <= ACSRS_MODE_AUTO;
        cur_ch <= next_ch; // begin at next enabled channel above current, wrapping to lowest
      end else if (cs_fall) begin
        unique case (mode)
          ACSRS_MODE_MANUAL: cur_ch <= cur_ch;
          ACSRS_MODE_AUTO: if (any_en) cur_ch <= next_ch;
        endcase
      end
    end
  end

  // sample descriptor latched at the chip-select fall; the host's spacing of
  // those falls is what keeps the aggregate rate legal, nothing here paces it
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_sample <= '0;
      o_sample_strobe <= 1'b0;
    end else if (i_ce) begin
      o_sample_strobe <= cs_fall;
      if (cs_fall) begin
        o_sample.channel <= cur_ch;
        o_sample.range_code <= channel_input_range_code[cur_ch];
        o_sample.bipolar <= !channel_input_range_code[cur_ch][2];
      end
    end
  end

  // status mirrors, registered so every output comes from a flop
  generate
    for (genvar c = 0; c < NUM_CH; c++) begin : g_rng
      always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
          o_channel_input_range_code[c*RANGE_W +: RANGE_W] <= RANGE_RESET;
        end else if (i_ce) begin
          o_channel_input_range_code[c*RANGE_W +: RANGE_W] <= channel_input_range_code[c];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_mode <= ACSRS_MODE_MANUAL;
      o_scan_en <= SCAN_EN_RESET;
    end else if (i_ce) begin
      o_mode <= mode;
      o_scan_en <= scan_en;
    end
  end

  // reference steering: pin is driven only while the strap selects internal
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_ref_internal <= 1'b0;
      o_reference_inout_pin <= 1'b0;
      o_reference_inout_pin_oe <= 1'b0;
      o_ref_sense <= 1'b0;
    end else if (i_ce) begin
      o_ref_internal <= !refsrc_sync;
      o_reference_inout_pin <= !refsrc_sync;
      o_reference_inout_pin_oe <= !refsrc_sync;
      o_ref_sense <= refsrc_sync ? refpin_sync : 1'b0;
    end
  end

  // assertions; the auto-scan step is one shared sequence, and a mask write in
  // the same cycle is left out because it moves the target under the check
  sequence s_auto_fall;
    i_ce && mode == ACSRS_MODE_AUTO && cs_fall && !i_manual_channel_select_command && !i_auto_start
      && !i_scan_en_wr;
  endsequence

  a_cs_fall_strobe: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_ce && cs_fall) |=> o_sample_strobe)
    else $error("strobe missing after chip-select fall");
  a_range_reset_zero: assert property (@(posedge i_clk_sys)
    !i_rst_n |=> channel_input_range_code[0] == RANGE_RESET
      && channel_input_range_code[NUM_CH-1] == RANGE_RESET)
    else $error("range code not reset");
  a_manual_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_ce && i_manual_channel_select_command) |=> cur_ch == $past(i_manual_ch))
    else $error("manual channel not taken");
  a_auto_enabled: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (s_auto_fall ##0 any_en) |=> scan_en[cur_ch])
    else $error("scan landed on disabled channel");
  a_auto_ascend: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (s_auto_fall ##0 ((scan_en & ~((8'h02 << cur_ch) - 8'h01)) != '0)) |=> cur_ch > $past(cur_ch))
    else $error("auto scan did not ascend");
  a_auto_wrap: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (s_auto_fall ##0 (any_en && (scan_en & ~((8'h02 << cur_ch) - 8'h01)) == '0))
      |=> scan_en[cur_ch] && (scan_en & ((8'h01 << cur_ch) - 8'h01)) == '0)
    else $error("auto scan did not wrap to lowest");
  a_ref_oe_int: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_ce && !refsrc_sync) |=> o_reference_inout_pin_oe && o_ref_internal)
    else $error("internal reference pin not driven");
  a_ref_oe_ext: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_ce && refsrc_sync) |=> !o_reference_inout_pin_oe)
    else $error("reference pin driven in external mode");
  a_range_write: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_ce && i_range_wr) |=> channel_input_range_code[$past(i_range_ch)] == $past(i_range_code))
    else $error("range write lost");
endmodule : acsrs_top

// *** dv/acsrs_host.sv ***
/*
 * host model for the sequencer: pulses the command strobes and paces chip select.
 * assumes the bench clock and that every input changes on its falling edge.
 */
module acsrs_host (
  input wire logic i_clk,
  output logic o_cs_n,
  output logic o_range_wr,
  output logic [acsrs_pkg::CH_W-1:0] o_range_ch,
  output logic [acsrs_pkg::RANGE_W-1:0] o_range_code,
  output logic o_man,
  output logic [acsrs_pkg::CH_W-1:0] o_man_ch,
  output logic o_auto,
  output logic o_scan_wr,
  output logic [acsrs_pkg::NUM_CH-1:0] o_scan_en
);
  timeunit 1ns;
  timeprecision 1ps;
  import acsrs_pkg::*;

  // idle state: select high, strobes low
  initial begin
    {o_cs_n, o_range_wr, o_man, o_auto, o_scan_wr} = 5'h10;
    {o_range_ch, o_range_code, o_man_ch, o_scan_en} = 18'h0_0000;
  end

  // data fields go to the inverse once the strobe is gone, so no stale value passes
  task automatic wr_range(input logic [CH_W-1:0] ch, input logic [RANGE_W-1:0] code);
    @(negedge i_clk);
    {o_range_ch, o_range_code, o_range_wr} = {ch, code, 1'b1};
    @(negedge i_clk);
    {o_range_ch, o_range_code, o_range_wr} = {~ch, ~code, 1'b0};
  endtask : wr_range

  // one register write picks the channel of the next sample
  task automatic man(input logic [CH_W-1:0] ch);
    @(negedge i_clk);
    {o_man_ch, o_man} = {ch, 1'b1};
    @(negedge i_clk);
    {o_man_ch, o_man} = {~ch, 1'b0};
  endtask : man

  task automatic go();
    @(negedge i_clk);
    o_auto = 1'b1;
    @(negedge i_clk);
    o_auto = 1'b0;
  endtask : go

  task automatic scan(input logic [NUM_CH-1:0] en);
    @(negedge i_clk);
    {o_scan_en, o_scan_wr} = {en, 1'b1};
    @(negedge i_clk);
    {o_scan_en, o_scan_wr} = {~en, 1'b0};
  endtask : scan

  // one frame per minimum sample spacing plus one cycle keeps the aggregate just under the rate ceiling
  task automatic sample();
    @(negedge i_clk);
    o_cs_n = 1'b0;
    repeat (4) @(negedge i_clk);
    o_cs_n = 1'b1;
    repeat (MIN_SAMPLE_CYC - 4) @(negedge i_clk);
  endtask : sample
endmodule : acsrs_host

// *** dv/tb_acsrs_top.sv ***
/*
 * self-checking bench for the sequencer and range select block.
 * assumes the host model drives commands and chip select on the falling edge.
 */
module tb_acsrs_top;
  timeunit 1ns;
  timeprecision 1ps;
  import acsrs_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, ref_src = 1'b0, ref_ext = 1'b0, pin;
  int num_errors = 0, num_checks = 0, strobes = 0;
  logic [RANGE_W-1:0] codes [5] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h6};
  logic [RANGE_W-1:0] exp_rng [NUM_CH];
  logic cs_n, rwr, man, au, swr, stb, r_int, r_out, r_oe, r_sense;
  logic [CH_W-1:0] rch, mch;
  logic [RANGE_W-1:0] rcode;
  logic [NUM_CH-1:0] sen, scan;
  logic [NUM_CH*RANGE_W-1:0] rng;
  acsrs_sample_t smp;
  acsrs_mode_t mode;

  // the pin level is whoever drives it: the block when enabled, else the outside source
  assign pin = r_oe ? r_out : ref_ext;

  acsrs_host u_host (.i_clk(clk), .o_cs_n(cs_n), .o_range_wr(rwr), .o_range_ch(rch), .o_range_code(rcode),
    .o_man(man), .o_man_ch(mch), .o_auto(au), .o_scan_wr(swr), .o_scan_en(sen));
  acsrs_top u_dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_ce(ce), .i_cs_n(cs_n), .i_range_wr(rwr),
    .i_range_ch(rch), .i_range_code(rcode), .i_manual_channel_select_command(man), .i_manual_ch(mch),
    .i_auto_start(au), .i_scan_en_wr(swr), .i_scan_en(sen), .i_reference_source_pin(ref_src),
    .i_reference_inout_pin(pin), .o_sample(smp), .o_sample_strobe(stb), .o_mode(mode), .o_scan_en(scan),
    .o_channel_input_range_code(rng), .o_ref_internal(r_int), .o_reference_inout_pin(r_out),
    .o_reference_inout_pin_oe(r_oe), .o_ref_sense(r_sense));

  initial begin
    forever #4 clk = ~clk;
  end

  // counts strobes so each chip-select fall must give exactly one; looked at
  // mid-cycle so the edge that launches the strobe is never raced
  always @(negedge clk) begin
    if (stb === 1'b1) strobes++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // one chip-select frame, then the sample must name ch with its range
  task automatic take(input logic [CH_W-1:0] ch);
    int n;
    n = strobes;
    u_host.sample();
    chk(32'(strobes), 32'(n + 1));
    chk(32'(smp.channel), 32'(ch));
    chk(32'(smp.range_code), 32'(exp_rng[ch]));
    chk(32'(smp.bipolar), 32'(!exp_rng[ch][2]));
  endtask : take

  task automatic t_reset();
    chk(rng, 32'h0000_0000);
    chk(32'(scan), 32'h0000_00ff);
    chk(32'(mode), 32'(ACSRS_MODE_MANUAL));
  endtask : t_reset

  task automatic t_range();
    for (int c = 0; c < NUM_CH; c++) begin
      exp_rng[c] = codes[c % 5];
      u_host.wr_range(c[CH_W-1:0], exp_rng[c]);
    end
    repeat (3) @(negedge clk);
    for (int c = 0; c < NUM_CH; c++) chk(32'(rng[c*RANGE_W+:RANGE_W]), 32'(exp_rng[c]));
  endtask : t_range

  task automatic t_manual();
    u_host.man(3'h5);
    u_host.man(3'h7);
    take(3'h7);
    take(3'h7);
  endtask : t_manual

  // mask 0,3,5 from channel 7: start wraps to 0, then 3, 5 and back to 0;
  // a manual command then leaves auto-scan and pins the channel
  task automatic t_auto();
    u_host.scan(8'h29);
    u_host.go();
    repeat (2) @(negedge clk);
    chk(32'(mode), 32'(ACSRS_MODE_AUTO));
    chk(32'(scan), 32'h0000_0029);
    take(3'h0);
    take(3'h3);
    take(3'h5);
    take(3'h0);
    u_host.man(3'h3);
    take(3'h3);
    chk(32'(mode), 32'(ACSRS_MODE_MANUAL));
  endtask : t_auto

  // external mode: the pin is released and its outside level is what is sensed
  task automatic t_ref();
    chk(32'({r_int, r_oe, r_out}), 32'h0000_0007);
    ref_src = 1'b1;
    ref_ext = 1'b1;
    repeat (4) @(negedge clk);
    chk(32'({r_int, r_oe, r_out, r_sense}), 32'h0000_0001);
    ref_ext = 1'b0;
    repeat (4) @(negedge clk);
    chk(32'(r_sense), 32'h0000_0000);
  endtask : t_ref

  // a range write while the clock enable is low must not be taken
  task automatic t_ce();
    @(negedge clk);
    ce = 1'b0;
    u_host.wr_range(3'h0, 4'h6);
    ce = 1'b1;
    repeat (3) @(negedge clk);
    chk(32'(rng[RANGE_W-1:0]), 32'(exp_rng[0]));
  endtask : t_ce

  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  // about 2000 cycles are needed; a hang is cut off well beyond that
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    complete_run();
  end

  initial begin
    repeat (2) @(negedge clk);
    t_reset();
    rst_n = 1'b1;
    t_range();
    t_ce();
    t_manual();
    t_auto();
    t_ref();
    complete_run();
  end
endmodule : tb_acsrs_top
